//--- emoc_defines.svh
// Purpose: Offsets, field positions, reset values and timing figures
// Assumes: Registers are 32-bit words at byte address 4 x index
// Notes:   Definitions only
`ifndef EMOC_DEFINES_SVH
`define EMOC_DEFINES_SVH

// Register indices
`define EMOC_IDX_MASK  6'h1a
`define EMOC_IDX_OCTL  6'h1b
`define EMOC_IDX_CFG   6'h30
`define EMOC_IDX_STAT  6'h31
`define EMOC_IDX_IRQ   6'h32
`define EMOC_IDX_IEN   6'h33
`define EMOC_IDX_ANG   6'h34

// Reset values and writable bits
`define EMOC_MASK_RST  24'h000080
`define EMOC_MASK_USED 24'heffeff
`define EMOC_OCTL_RST  26'h0000000
`define EMOC_OCTL_USED 26'h3ff7fff
`define EMOC_CFG_RST   15'h0000
`define EMOC_CFG_USED  15'h700f

// Field positions
`define EMOC_OCTL_ADJ   24
`define EMOC_OCTL_PWMEN 23
`define EMOC_OCTL_BAND  20
`define EMOC_OCTL_STEP  16
`define EMOC_OCTL_HYST  14
`define EMOC_MASK_PLL   7
`define EMOC_CFG_SADR   0
`define EMOC_CFG_DADR   1
`define EMOC_CFG_ZSLOT  2
`define EMOC_CFG_NOSMP  3
`define EMOC_CFG_MODE  12

// Interrupt event count and function pulse minimum
`define EMOC_IRQ_W     5
`define EMOC_FP_MIN    8'd9

// Timing
`define EMOC_CLK_NS       10
`define EMOC_CAR_BASE_NS  280000
`define EMOC_CAR_STEP_NS  2500
`endif

//--- emoc_pkg.sv
// Purpose: Types shared by the output configuration block
// Assumes: Nothing
// Notes:   Enum order gives the documented mode codes
package emoc_pkg;
  typedef enum logic [2:0] {
    EMOC_SENT_OFF, EMOC_SENT_STR, EMOC_SENT_STRP, EMOC_SENT_TRG,
    EMOC_SENT_TRGL, EMOC_SENT_ADR, EMOC_SENT_SEQ, EMOC_SENT_SEQL
  } emoc_field_a_t;
  typedef enum logic [1:0] {EMOC_PIN_SPI, EMOC_PIN_SENT, EMOC_PIN_PWM} emoc_pin_t;
  typedef enum logic {EMOC_BUS_IDLE, EMOC_BUS_ACK} emoc_bus_t;
endpackage

//--- emoc_link_if.sv
// Purpose: Carries configuration and results between top and helpers
// Assumes: Single clock domain
// Notes:   No clocking block
`timescale 1ns/1ps
interface emoc_link_if;
  import emoc_pkg::*;
  logic            pwm_run;
  logic [2:0]      band;
  logic [3:0]      step;
  logic            car_tick;
  logic [19:0]     period;
  logic            no_samp;
  logic            zero_samp;
  logic            diag_addr;
  logic            samp_addr;
  logic [1:0]      function_pulse_adjust;
  emoc_field_a_t mode;
  logic            hold;
  logic            diag;
  logic            fp_out;
  modport ctl (output pwm_run, band, step, no_samp, zero_samp, diag_addr,
               samp_addr, function_pulse_adjust, mode, input car_tick, period, hold, diag, fp_out);
  modport car (input pwm_run, band, step, output car_tick, period);
  modport smp (input no_samp, zero_samp, diag_addr, samp_addr, function_pulse_adjust, mode,
               output hold, diag, fp_out);
endinterface

//--- emoc_carrier.sv
// Purpose: PWM carrier period and one-cycle carrier tick
// Assumes: Band and step are register outputs on the same clock
// Notes:   Period = base + step x ((16 + step field) << band)
`timescale 1ns/1ps
module emoc_carrier #(
  parameter int unsigned BASE_CYC = 28000,
  parameter int unsigned STEP_CYC = 250
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // Link to top
  emoc_link_if.car lnk
);
  import emoc_pkg::*;

  logic [19:0] cnt_r;
  logic [19:0] period_r;
  logic        tick_r;

  // Closed form of the carrier table, 3125 Hz down to 98 Hz
  function automatic logic [19:0] car_period(input logic [2:0] band,
                                             input logic [3:0] step);
    logic [11:0] units;
    units = 12'((12'd16 + {8'h00, step}) << band);
    car_period = 20'(BASE_CYC + STEP_CYC * units);
  endfunction

  // Counter restarts whenever PWM is off, so a new carrier starts clean
  always_ff @(posedge sys_clk_i)
  begin
    period_r <= car_period(lnk.band, lnk.step);
    if (rst_i || !lnk.pwm_run)
    begin
      cnt_r  <= 20'h00000;
      tick_r <= 1'b0;
    end
    else if (cnt_r >= period_r - 20'h00001)
    begin
      cnt_r  <= 20'h00000;
      tick_r <= 1'b1;
    end
    else
    begin
      cnt_r  <= cnt_r + 20'h00001;
      tick_r <= 1'b0;
    end
  end

  assign lnk.car_tick = tick_r;
  assign lnk.period   = period_r;
endmodule

//--- emoc_sampler.sv
// Purpose: Sample-and-hold, diagnostic entry and output pulse decisions
// Assumes: Pulse inputs are one-cycle strobes on sys_clk_i
// Notes:   All results are registered one cycle after the strobe
`timescale 1ns/1ps
`include "emoc_defines.svh"
module emoc_sampler (
  // Clock and reset
  input wire logic       sys_clk_i,
  input wire logic       rst_i,
  // Function pulse strobes
  input wire logic       fp_sample_i,
  input wire logic       fp_diag_i,
  input wire logic       fp_addr_match_i,
  input wire logic       slot_zero_i,
  input wire logic       low_done_i,
  input wire logic [7:0] low_ticks_i,
  // Link to top
  emoc_link_if.smp       lnk
);
  import emoc_pkg::*;

  logic       hold_r;
  logic       diag_r;
  logic       fp_r;
  wire        seq_w   = (lnk.mode == EMOC_SENT_SEQ) || (lnk.mode == EMOC_SENT_SEQL);
  wire        long_w  = (lnk.mode == EMOC_SENT_SEQL);
  // No-sample blocks pulses; addressing narrows them to this device
  wire        pulse_w = fp_sample_i && !lnk.no_samp
                        && (!lnk.samp_addr || fp_addr_match_i);
  wire        slot_w  = slot_zero_i && lnk.zero_samp && seq_w;
  wire        diag_w  = fp_diag_i && (!lnk.diag_addr || fp_addr_match_i);
  // Raised threshold only in long mode, 9 to 12 ticks
  wire [7:0]  min_w   = `EMOC_FP_MIN + (long_w ? {6'h00, lnk.function_pulse_adjust} : 8'h00);
  wire        fpo_w   = low_done_i && (low_ticks_i >= min_w);

  // Registered decisions
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      hold_r <= 1'b0;
      diag_r <= 1'b0;
      fp_r   <= 1'b0;
    end
    else
    begin
      hold_r <= pulse_w || slot_w;
      diag_r <= diag_w;
      fp_r   <= fpo_w;
    end
  end

  assign lnk.hold   = hold_r;
  assign lnk.diag   = diag_r;
  assign lnk.fp_out = fp_r;
endmodule

//--- emoc_top.sv
// Purpose: Error mask and output control registers of the angle output path
// Assumes: Avalon-MM slave, byte address, one 32-bit word per register
// Notes:   All event inputs are logic on sys_clk_i, so none is synchronised
//
// Local design decision: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "emoc_defines.svh"

// Functional notes
// - No-sample bit blocks sample pulse holds
// - Zero-slot bit samples when slot returns zero
// - Diag addressing bit gates diagnostic entry
// - Sample addressing bit gates sample pulses
// - Mask bit keeps flag from summary error
// - Masks suppress soft errors, never hard
// - Each mask bit blocks own flag only
// - Watchdog-named mask bit covers oscillator fault
// - Pll unlock always a hard error
// - Long mode raises function pulse minimum
// - Pwm enable wins pin, disables sent
// - Neither enabled gives spi on pin
// - Band and step fields pick carrier
// - Hysteresis enable applies output hysteresis
// - Slot-zero sampling only in sequential modes
module emoc_top #(
  parameter int unsigned CAR_BASE_CYC = `EMOC_CAR_BASE_NS / `EMOC_CLK_NS,
  parameter int unsigned CAR_STEP_CYC = `EMOC_CAR_STEP_NS / `EMOC_CLK_NS
) (
  // Clock and reset
  input  wire logic              sys_clk_i,
  input  wire logic              rst_i,
  // Avalon-MM slave
  input  wire logic [7:0]        avs_address_i,
  input  wire logic              avs_read_i,
  input  wire logic              avs_write_i,
  input  wire logic [31:0]       avs_writedata_i,
  input  wire logic [3:0]        avs_byteenable_i,
  output      logic [31:0]       avs_readdata_o,
  output      logic              avs_waitrequest_o,
  // Error sources
  input  wire logic [23:0]       err_flags_i,
  input  wire logic [23:0]       soft_flags_i,
  input  wire logic              hard_flags_i,
  // Function pulses and angle
  input  wire logic              fp_sample_i,
  input  wire logic              fp_diag_i,
  input  wire logic              fp_addr_match_i,
  input  wire logic              slot_zero_i,
  input  wire logic              low_done_i,
  input  wire logic [7:0]        low_ticks_i,
  input  wire logic [15:0]       angle_i,
  // Output path control
  output      logic              summary_error_o,
  output      logic              sent_soft_err_o,
  output      logic              sent_hard_err_o,
  output      emoc_pkg::emoc_pin_t       pin_mode_o,
  output      emoc_pkg::emoc_field_a_t field_a_o,
  output      logic              carrier_tick_o,
  output      logic [19:0]       carrier_period_o,
  output      logic              hyst_en_o,
  output      logic [15:0]       held_angle_o,
  output      logic              hold_o,
  output      logic              diag_enter_o,
  output      logic              fp_out_o,
  output      logic              irq_o
);
  import emoc_pkg::*;

  emoc_link_if lnk ();

  // Registers
  emoc_bus_t                bus_st_r;
  logic [23:0]              mask_r;
  logic [25:0]              octl_r;
  logic [14:0]              cfg_r;
  logic [`EMOC_IRQ_W-1:0]   irq_sts_r;
  logic [`EMOC_IRQ_W-1:0]   irq_ien_r;
  logic [15:0]              angle_d_r;

  // Byte-lane merge, shared by every writable register
  function automatic logic [31:0] be_merge(input logic [31:0] old,
                                           input logic [31:0] wdat,
                                           input logic [3:0]  be);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++)
    begin
      if (be[i])
      begin
        res[i*8 +: 8] = wdat[i*8 +: 8];
      end
    end
    be_merge = res;
  endfunction

  // Bus decode
  wire [5:0]  idx_w    = avs_address_i[7:2];
  wire        req_w    = avs_read_i || avs_write_i;
  wire        ack_w    = (bus_st_r == EMOC_BUS_ACK);
  wire        wr_go_w  = avs_write_i && ack_w;
  wire        rd_go_w  = avs_read_i && ack_w;
  wire        wr_mask_w = wr_go_w && (idx_w == `EMOC_IDX_MASK);
  wire        wr_octl_w = wr_go_w && (idx_w == `EMOC_IDX_OCTL);
  wire        wr_cfg_w = wr_go_w && (idx_w == `EMOC_IDX_CFG);
  wire        wr_ien_w = wr_go_w && (idx_w == `EMOC_IDX_IEN);
  wire        rd_irq_w = rd_go_w && (idx_w == `EMOC_IDX_IRQ);

  // Writes keep only populated bits; bits 20 and 8 of the mask stay zero
  wire [31:0] mask_wr_w = be_merge({8'h00, mask_r}, avs_writedata_i, avs_byteenable_i);
  wire [31:0] octl_wr_w = be_merge({6'h00, octl_r}, avs_writedata_i, avs_byteenable_i);
  wire [31:0] cfg_wr_w = be_merge({17'h00000, cfg_r}, avs_writedata_i, avs_byteenable_i);
  wire [31:0] ien_wr_w = be_merge({27'h0000000, irq_ien_r}, avs_writedata_i,
                                  avs_byteenable_i);
  wire [23:0] mask_nxt = mask_wr_w[23:0] & `EMOC_MASK_USED;
  wire [25:0] octl_nxt = octl_wr_w[25:0] & `EMOC_OCTL_USED;
  wire [14:0] cfg_nxt  = cfg_wr_w[14:0] & `EMOC_CFG_USED;

  // Configuration fields
  wire             pwm_en_w = octl_r[`EMOC_OCTL_PWMEN];
  emoc_field_a_t mode_w;
  assign mode_w = emoc_field_a_t'(cfg_r[`EMOC_CFG_MODE +: 3]);

  // Summary error: mask bit n blocks flag n only; bit 4 covers the oscillator fault
  wire [23:0] eff_err_w  = err_flags_i & ~mask_r & `EMOC_MASK_USED;
  wire        sum_nxt    = |eff_err_w;
  // Soft flags obey the mask, hard flags and pll unlock never do
  wire        soft_nxt   = |(soft_flags_i & ~mask_r & `EMOC_MASK_USED);
  wire        hard_nxt   = hard_flags_i || err_flags_i[`EMOC_MASK_PLL];

  // Pin selection: pwm first, then sent, else spi data out
  emoc_pin_t       pin_nxt;
  emoc_field_a_t smode_nxt;
  assign pin_nxt   = pwm_en_w ? EMOC_PIN_PWM :
                     (mode_w != EMOC_SENT_OFF) ? EMOC_PIN_SENT : EMOC_PIN_SPI;
  assign smode_nxt = pwm_en_w ? EMOC_SENT_OFF : mode_w;

  // Interrupt events: summary rise, hard rise, diag, hold, output pulse
  wire [`EMOC_IRQ_W-1:0] ev_w  = {lnk.fp_out, lnk.hold, lnk.diag,
                                  hard_nxt && !sent_hard_err_o,
                                  sum_nxt && !summary_error_o};
  // Only bits that were returned by the read are cleared, so a new event wins
  wire [`EMOC_IRQ_W-1:0] clr_w = rd_irq_w ? avs_readdata_o[`EMOC_IRQ_W-1:0]
                                          : {`EMOC_IRQ_W{1'b0}};
  wire [`EMOC_IRQ_W-1:0] irq_nxt = (irq_sts_r & ~clr_w) | ev_w;

  // Read mux; unmapped addresses read zero
  logic [31:0] rd_mux;
  assign rd_mux =
    (idx_w == `EMOC_IDX_MASK) ? {8'h00, mask_r} :
    (idx_w == `EMOC_IDX_OCTL) ? {6'h00, octl_r} :
    (idx_w == `EMOC_IDX_CFG)  ? {17'h00000, cfg_r} :
    (idx_w == `EMOC_IDX_STAT) ? {24'h000000, pin_mode_o, sent_hard_err_o,
                                 sent_soft_err_o, summary_error_o, 3'h0} :
    (idx_w == `EMOC_IDX_IRQ)  ? {27'h0000000, irq_sts_r} :
    (idx_w == `EMOC_IDX_IEN)  ? {27'h0000000, irq_ien_r} :
    (idx_w == `EMOC_IDX_ANG)  ? {16'h0000, held_angle_o} : 32'h00000000;

  // Link configuration to helpers
  assign lnk.pwm_run   = pwm_en_w;
  assign lnk.band      = octl_r[`EMOC_OCTL_BAND +: 3];
  assign lnk.step      = octl_r[`EMOC_OCTL_STEP +: 4];
  assign lnk.no_samp   = cfg_r[`EMOC_CFG_NOSMP];
  assign lnk.zero_samp = cfg_r[`EMOC_CFG_ZSLOT];
  assign lnk.diag_addr = cfg_r[`EMOC_CFG_DADR];
  assign lnk.samp_addr = cfg_r[`EMOC_CFG_SADR];
  assign lnk.function_pulse_adjust    = octl_r[`EMOC_OCTL_ADJ +: 2];
  assign lnk.mode      = mode_w;

  emoc_carrier #(
    .BASE_CYC (CAR_BASE_CYC),
    .STEP_CYC (CAR_STEP_CYC)
  ) u_car (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .lnk       (lnk.car)
  );

  emoc_sampler u_smp (
    .sys_clk_i       (sys_clk_i),
    .rst_i           (rst_i),
    .fp_sample_i     (fp_sample_i),
    .fp_diag_i       (fp_diag_i),
    .fp_addr_match_i (fp_addr_match_i),
    .slot_zero_i     (slot_zero_i),
    .low_done_i      (low_done_i),
    .low_ticks_i     (low_ticks_i),
    .lnk             (lnk.smp)
  );

  // Bus handshake: one wait cycle, then a single-cycle acknowledge
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      bus_st_r          <= EMOC_BUS_IDLE;
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o    <= 32'h00000000;
    end
    else if (!ack_w && req_w)
    begin
      bus_st_r          <= EMOC_BUS_ACK;
      avs_waitrequest_o <= 1'b0;
      avs_readdata_o    <= avs_read_i ? rd_mux : 32'h00000000;
    end
    else
    begin
      bus_st_r          <= EMOC_BUS_IDLE;
      avs_waitrequest_o <= 1'b1;
    end
  end

  // Software registers; the pll mask resets set for sent use
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      mask_r    <= `EMOC_MASK_RST;
      octl_r    <= `EMOC_OCTL_RST;
      cfg_r     <= `EMOC_CFG_RST;
      irq_ien_r <= {`EMOC_IRQ_W{1'b0}};
      irq_sts_r <= {`EMOC_IRQ_W{1'b0}};
    end
    else
    begin
      if (wr_mask_w) mask_r <= mask_nxt;
      if (wr_octl_w) octl_r <= octl_nxt;
      if (wr_cfg_w) cfg_r <= cfg_nxt;
      if (wr_ien_w) irq_ien_r <= ien_wr_w[`EMOC_IRQ_W-1:0];
      irq_sts_r <= irq_nxt;
    end
  end

  // Error outputs and pin selection, registered for clean outputs
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      summary_error_o <= 1'b0;
      sent_soft_err_o <= 1'b0;
      sent_hard_err_o <= 1'b0;
      pin_mode_o      <= EMOC_PIN_SPI;
      field_a_o     <= EMOC_SENT_OFF;
      hyst_en_o       <= 1'b0;
      irq_o           <= 1'b0;
    end
    else
    begin
      summary_error_o <= sum_nxt;
      sent_soft_err_o <= soft_nxt;
      sent_hard_err_o <= hard_nxt;
      pin_mode_o      <= pin_nxt;
      field_a_o     <= smode_nxt;
      hyst_en_o       <= octl_r[`EMOC_OCTL_HYST];
      irq_o           <= |(irq_nxt & irq_ien_r);
    end
  end

  // Held angle: delayed copy lines up with the sampler's registered decision
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      angle_d_r        <= 16'h0000;
      held_angle_o     <= 16'h0000;
      hold_o           <= 1'b0;
      diag_enter_o     <= 1'b0;
      fp_out_o         <= 1'b0;
      carrier_tick_o   <= 1'b0;
      carrier_period_o <= 20'h00000;
    end
    else
    begin
      angle_d_r        <= angle_i;
      if (lnk.hold) held_angle_o <= angle_d_r;
      hold_o           <= lnk.hold;
      diag_enter_o     <= lnk.diag;
      fp_out_o         <= lnk.fp_out;
      carrier_tick_o   <= lnk.car_tick;
      carrier_period_o <= lnk.period;
    end
  end

  // Checks
  wire seq_chk = (mode_w == EMOC_SENT_SEQ) || (mode_w == EMOC_SENT_SEQL);
  wire slot_chk = slot_zero_i && cfg_r[`EMOC_CFG_ZSLOT] && seq_chk;

  property p_no_sample;
    @(posedge sys_clk_i) disable iff (rst_i)
      (fp_sample_i && cfg_r[`EMOC_CFG_NOSMP] && !slot_chk) |-> ##2 !hold_o;
  endproperty
  a_no_sample: assert property (p_no_sample)
    else $error("sample pulse held despite no-sample");

  property p_sample_hold;
    @(posedge sys_clk_i) disable iff (rst_i)
      (fp_sample_i && !cfg_r[`EMOC_CFG_NOSMP] && !cfg_r[`EMOC_CFG_SADR])
        |-> ##2 (hold_o && held_angle_o == $past(angle_i, 2));
  endproperty
  a_sample_hold: assert property (p_sample_hold)
    else $error("broadcast sample did not latch angle");

  property p_zero_slot;
    @(posedge sys_clk_i) disable iff (rst_i)
      slot_chk |-> ##2 hold_o;
  endproperty
  a_zero_slot: assert property (p_zero_slot)
    else $error("slot zero did not sample");

  property p_diag;
    @(posedge sys_clk_i) disable iff (rst_i)
      fp_diag_i |-> ##2 (diag_enter_o ==
                         (!$past(cfg_r[`EMOC_CFG_DADR], 2) || $past(fp_addr_match_i, 2)));
  endproperty
  a_diag: assert property (p_diag)
    else $error("diagnostic entry wrong for addressing");

  property p_samp_addr;
    @(posedge sys_clk_i) disable iff (rst_i)
      (fp_sample_i && cfg_r[`EMOC_CFG_SADR] && !fp_addr_match_i && !slot_chk)
        |-> ##2 !hold_o;
  endproperty
  a_samp_addr: assert property (p_samp_addr)
    else $error("unaddressed sample was held");

  property p_summary;
    @(posedge sys_clk_i) disable iff (rst_i)
      ((err_flags_i & ~mask_r & `EMOC_MASK_USED) == 24'h000000) |=> !summary_error_o;
  endproperty
  a_summary: assert property (p_summary)
    else $error("masked flag reached summary error");

  property p_hard;
    @(posedge sys_clk_i) disable iff (rst_i)
      err_flags_i[`EMOC_MASK_PLL] |=> sent_hard_err_o;
  endproperty
  a_hard: assert property (p_hard)
    else $error("pll unlock not reported as hard error");

  property p_soft;
    @(posedge sys_clk_i) disable iff (rst_i)
      ((soft_flags_i & ~mask_r) == 24'h000000) |=> !sent_soft_err_o;
  endproperty
  a_soft: assert property (p_soft)
    else $error("masked soft flag asserted");

  property p_pwm_wins;
    @(posedge sys_clk_i) disable iff (rst_i)
      pwm_en_w |=> (pin_mode_o == EMOC_PIN_PWM && field_a_o == EMOC_SENT_OFF);
  endproperty
  a_pwm_wins: assert property (p_pwm_wins)
    else $error("pwm enable did not take the pin");

  property p_spi_pin;
    @(posedge sys_clk_i) disable iff (rst_i)
      (!pwm_en_w && mode_w == EMOC_SENT_OFF) |=> pin_mode_o == EMOC_PIN_SPI;
  endproperty
  a_spi_pin: assert property (p_spi_pin)
    else $error("pin not spi with both outputs off");

  property p_fp_min;
    @(posedge sys_clk_i) disable iff (rst_i)
      (low_done_i && low_ticks_i < `EMOC_FP_MIN) |-> ##2 !fp_out_o;
  endproperty
  a_fp_min: assert property (p_fp_min)
    else $error("short low pulse taken as function pulse");

  property p_resv;
    @(posedge sys_clk_i) disable iff (rst_i)
      (wr_mask_w || wr_octl_w)
        |=> (mask_r[20] == 1'b0 && mask_r[8] == 1'b0 && octl_r[15] == 1'b0);
  endproperty
  a_resv: assert property (p_resv)
    else $error("unused bit took a written value");

  property p_car_base;
    @(posedge sys_clk_i) disable iff (rst_i)
      (octl_r[`EMOC_OCTL_STEP +: 7] == 7'h00) [*3]
        |-> carrier_period_o == 20'(CAR_BASE_CYC + 16 * CAR_STEP_CYC);
  endproperty
  a_car_base: assert property (p_car_base)
    else $error("carrier period wrong at band 0 step 0");
endmodule

//--- emoc_fp_model.sv
// Purpose: Control unit side that issues function pulses
// Assumes: One clock; every pulse is one cycle wide
// Notes:   Match and tick lines it releases show inverted data, never the last value
`timescale 1ns/1ps
module emoc_fp_model (
  // Clock
  input  wire logic       clk_i,
  // Pulse lines
  output      logic       samp_o,
  output      logic       diag_o,
  output      logic       match_o,
  output      logic       slot_o,
  output      logic       low_o,
  output      logic [7:0] ticks_o
);
  // Quiet bus at time zero
  initial
  begin
    {samp_o, diag_o, slot_o, low_o, match_o, ticks_o} = '0;
  end

  // One pulse of kind k; the low width t comes from the caller, above or below the tick threshold
  task automatic send(input int k, input logic m, input logic [7:0] t);
    @(posedge clk_i);
    samp_o <= k == 0;
    diag_o <= k == 1;
    slot_o <= k == 2;
    low_o <= k == 3;
    match_o <= m;
    ticks_o <= t;
    @(posedge clk_i);
    {samp_o, diag_o, slot_o, low_o} <= '0;
    match_o <= ~m;
    ticks_o <= ~t;
  endtask
endmodule

//--- emoc_tb.sv
// Purpose: Self-checking bench of the error mask and output control block
// Assumes: Carrier counts shortened to 28 and 2 cycles
// Notes:   Read data are checked by the monitor against a queue
`timescale 1ns/1ps
module testbench;
  import emoc_pkg::*;
  logic            clk = 0, rst = 1, rd = 0, wr = 0, hf = 0;
  logic            wq, ht, dg, fo, ck, se, ss, sh, hy, ir, sp, dp, mp, zp, lp;
  logic [7:0]      adr = '0, lt;
  logic [31:0]     wd = '0, rdat, m, e, s;
  logic [23:0]     ef = '0, sf = '0;
  logic [15:0]     ang = '0, hang;
  logic [19:0]     per;
  emoc_pin_t       pm;
  emoc_field_a_t sm;
  int              err_total = 0, cmp_count = 0, nh = 0, nd = 0, nf = 0, nt = 0, b, f;
  logic [31:0]     q[$];

  emoc_top #(.CAR_BASE_CYC(28), .CAR_STEP_CYC(2)) emoc_top_i (
    .sys_clk_i(clk), .rst_i(rst), .avs_address_i(adr), .avs_read_i(rd),
    .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(4'hf),
    .avs_readdata_o(rdat), .avs_waitrequest_o(wq), .err_flags_i(ef),
    .soft_flags_i(sf), .hard_flags_i(hf), .fp_sample_i(sp), .fp_diag_i(dp),
    .fp_addr_match_i(mp), .slot_zero_i(zp), .low_done_i(lp), .low_ticks_i(lt),
    .angle_i(ang), .summary_error_o(se), .sent_soft_err_o(ss),
    .sent_hard_err_o(sh), .pin_mode_o(pm), .field_a_o(sm), .carrier_tick_o(ck),
    .carrier_period_o(per), .hyst_en_o(hy), .held_angle_o(hang), .hold_o(ht),
    .diag_enter_o(dg), .fp_out_o(fo), .irq_o(ir));
  emoc_fp_model emoc_fp_model_i (.clk_i(clk), .samp_o(sp), .diag_o(dp),
    .match_o(mp), .slot_o(zp), .low_o(lp), .ticks_o(lt));

  // Clock of 10 ns
  always #5 clk = ~clk;

  task automatic chk(input logic [31:0] v, input logic [31:0] x);
    cmp_count++;
    if (v !== x)
    begin
      err_total++;
      $display("wrong value at %0t: saw %h, expected %h", $time, v, x);
    end
  endtask

  task automatic summarize;
    $display("comparisons %0d, mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Holds the request until waitrequest is sampled low; the watchdog bounds it
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    adr <= a;
    wd <= d;
    wr <= w;
    rd <= !w;
    do
      @(posedge clk);
    while (wq !== 1'b0);
    rd <= 0;
    wr <= 0;
  endtask

  task automatic rx(input logic [7:0] a, input logic [31:0] x);
    q.push_back(x);
    acc(0, a, 0);
  endtask

  // One pulse case: config, control, kind, match, ticks, expected counts
  task automatic fp(input logic [31:0] c, p, input int k, input logic mt,
                    input logic [7:0] t, input int eh, ed, ef1);
    int h0, d0, f0;
    acc(1, 8'hc0, c);
    acc(1, 8'h6c, p);
    ang <= 16'($urandom);
    h0 = nh;
    d0 = nd;
    f0 = nf;
    emoc_fp_model_i.send(k, mt, t);
    wt(4);
    chk(nh - h0, eh);
    chk(nd - d0, ed);
    chk(nf - f0, ef1);
    if (eh)
      chk(hang, ang);
  endtask

  // Read data taken at the acknowledging edge; pulses counted as they come
  always @(posedge clk)
  begin
    if (rd && wq === 1'b0)
      chk(rdat, q.pop_front());
    nh += int'(ht === 1'b1);
    nd += int'(dg === 1'b1);
    nf += int'(fo === 1'b1);
    nt += int'(ck === 1'b1);
  end

  // Watchdog, far beyond the roughly 1200 cycles the tests need
  initial
  begin
    wt(30000);
    err_total++;
    summarize();
  end

  initial
  begin
    void'($urandom(38));
    wt(16);
    rst <= 0;
    rx(8'h68, 32'h80);
    rx(8'h6c, 32'h0);
    rx(8'hfc, 32'h0);
    $display("reset test done");
    acc(1, 8'hcc, 32'h8);
    emoc_fp_model_i.send(0, 0, 0);
    wt(5);
    chk(ir, 1);
    acc(1, 8'hcc, 32'h0);
    wt(2);
    chk(ir, 0);
    acc(1, 8'hcc, 32'h8);
    wt(2);
    chk(ir, 1);
    rx(8'hc8, 32'h8);
    wt(2);
    chk(ir, 0);
    $display("interrupt test done");
    acc(1, 8'h68, '1);
    rx(8'h68, 32'heffeff);
    acc(1, 8'h6c, '1);
    rx(8'h6c, 32'h3ff7fff);
    wt(2);
    chk(hy, 1);
    for (int i = 0; i < 12; i++)
    begin
      m = i ? $urandom & 32'heffeff : 32'h10;
      e = i ? $urandom & 32'heffeff : 32'h10;
      s = $urandom & 32'heffeff;
      acc(1, 8'h68, m);
      ef <= e[23:0];
      sf <= s[23:0];
      hf <= 1'($urandom);
      wt(3);
      chk(se, |(e & ~m));
      chk(ss, |(s & ~m));
      chk(sh, hf | e[7]);
    end
    ef <= '0;
    sf <= '0;
    hf <= 0;
    acc(1, 8'h68, 32'h80);
    $display("mask test done");
    acc(1, 8'h6c, 0);
    wt(2);
    chk(hy, 0);
    for (int k = 0; k < 8; k++)
    begin
      acc(1, 8'hc0, k << 12);
      wt(2);
      chk(pm, k ? EMOC_PIN_SENT : EMOC_PIN_SPI);
      chk(sm, k);
    end
    acc(1, 8'h6c, 32'h800000);
    wt(2);
    chk(pm, EMOC_PIN_PWM);
    chk(sm, 0);
    $display("pin test done");
    fp(0, 0, 0, 0, 0, 1, 0, 0);
    fp(8, 0, 0, 1, 0, 0, 0, 0);
    fp(1, 0, 0, 0, 0, 0, 0, 0);
    fp(1, 0, 0, 1, 0, 1, 0, 0);
    fp(9, 0, 0, 1, 0, 0, 0, 0);
    fp(2, 0, 1, 0, 0, 0, 0, 0);
    fp(2, 0, 1, 1, 0, 0, 1, 0);
    fp(0, 0, 1, 0, 0, 0, 1, 0);
    fp('h6004, 0, 2, 0, 0, 1, 0, 0);
    fp('h6000, 0, 2, 0, 0, 0, 0, 0);
    fp('h1004, 0, 2, 0, 0, 0, 0, 0);
    fp('h7000, 'h3000000, 3, 0, 11, 0, 0, 0);
    fp('h7000, 'h3000000, 3, 0, 12, 0, 0, 1);
    fp('h6000, 'h3000000, 3, 0, 9, 0, 0, 1);
    fp('h6000, 0, 3, 0, 8, 0, 0, 0);
    $display("pulse test done");
    for (int i = 0; i < 6; i++)
    begin
      b = i == 0 ? 0 : (i == 1 ? 7 : $urandom % 8);
      f = i == 0 ? 0 : (i == 1 ? 15 : $urandom % 16);
      acc(1, 8'h6c, 32'h800000 | b << 20 | f << 16);
      s = nt;
      wt(130);
      chk(per, 28 + 2 * ((16 + f) << b));
      if (i == 0)
        chk(nt - s > 1, 1);
    end
    $display("carrier test done");
    summarize();
  end
endmodule
